// [capture_pkg.sv]
// shared constants and carrier types for the input capture channel
package capture_pkg;

   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned BUF_DEPTH = 4;
   localparam int unsigned PTR_W = 2;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_DISABLE_TWO = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_BUFFER = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 4'hA;

   // field positions
   localparam int unsigned STOP_IDLE_POS = 13;
   localparam int unsigned TSEL_POS = 10;
   localparam int unsigned CPI_POS = 5;
   localparam int unsigned OVF_POS = 4;
   localparam int unsigned BNE_POS = 3;
   localparam int unsigned MODE_POS = 0;
   localparam int unsigned CH_DISABLE_POS = 8;

   // reset values
   localparam logic [DATA_W-1:0] CONTROL_RESET = 16'h0000;
   localparam logic [3:0] DISABLE_RESET = 4'h0;
   localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

   // time base select codes
   localparam logic [2:0] TB_TIMER_THREE = 3'h0;
   localparam logic [2:0] TB_TIMER_TWO = 3'h1;
   localparam logic [2:0] TB_TIMER_FOUR = 3'h2;
   localparam logic [2:0] TB_TIMER_FIVE = 3'h3;
   localparam logic [2:0] TB_PERIPH = 3'h7;

   // prescaler terminal counts and full buffer level
   localparam logic [3:0] PRESC_LIMIT_FOUR = 4'h3;
   localparam logic [3:0] PRESC_LIMIT_SIXTEEN = 4'hF;
   localparam logic [2:0] FILL_FULL = 3'h4;

   typedef enum logic [2:0] {
      MODE_OFF = 3'h0,
      MODE_BOTH_EDGES = 3'h1,
      MODE_SPARE = 3'h2,
      MODE_FALLING = 3'h3,
      MODE_RISE_FOUR = 3'h4,
      MODE_RISE_SIXTEEN = 3'h5,
      MODE_UNUSED = 3'h6,
      MODE_WAKE = 3'h7
   } mode_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] two;
      logic [DATA_W-1:0] three;
      logic [DATA_W-1:0] four;
      logic [DATA_W-1:0] five;
   } timer_values_t;

   typedef struct packed {
      logic wake;
      logic overflow;
      logic capture;
   } irq_bits_t;

   localparam irq_bits_t IRQ_RESET = 3'h0;

endpackage : capture_pkg

// [capture_buffer_mem.sv]
// small capture buffer memory with registered read data and write bypass
`timescale 1ns/1ps
`default_nettype none
module capture_buffer_mem (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [capture_pkg::PTR_W-1:0] wr_addr,
   input wire logic [capture_pkg::DATA_W-1:0] wr_data,
   input wire logic [capture_pkg::PTR_W-1:0] rd_addr,
   output logic [capture_pkg::DATA_W-1:0] rd_data
);

   typedef struct packed {
      logic [capture_pkg::BUF_DEPTH-1:0][capture_pkg::DATA_W-1:0] words;
      logic [capture_pkg::DATA_W-1:0] rd_data;
   } mem_state_t;

   mem_state_t m_q;
   mem_state_t m_d;

   always_comb
   begin
      m_d = m_q;
      if (wr_en)
      begin
         m_d.words[wr_addr] = wr_data;
      end
      // bypass so a word written this cycle is seen at once
      m_d.rd_data = m_d.words[rd_addr];
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         m_q <= '0;
      end
      else
      begin
         m_q <= m_d;
      end
   end

   assign rd_data = m_q.rd_data;

endmodule : capture_buffer_mem
`default_nettype wire

// [input_capture_control.sv]
// input capture channel: edge detect, time stamp buffer, registers and interrupt
// Function
// - stop-in-idle set halts the channel while the processor idles
// - time base select picks peripheral clock or timer two, three, four, five
// - captures per interrupt gives interrupt every capture or every second, third or fourth capture
// - captures per interrupt is ignored in modes 001 and 111
// - overflow flag reads one after buffer overflow, software cannot write it
// - buffer not empty reads one while a captured value is waiting
// - only hardware changes overflow and not-empty flags; here a software write of mode 000 also clears both
// - mode 111 is only a rising edge wake input in sleep or idle
// - mode 110 leaves the channel disabled
// - mode 101 captures every sixteenth rising edge, 100 every fourth
// - mode 011 captures every falling edge
// - mode 001 captures every rising and every falling edge
// - mode 000 switches the channel off
// - a set module disable bit disables its channel
// - unimplemented bits read zero and ignore writes
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module input_capture_control (
   input wire logic core_clk,
   input wire logic rst,
   input wire capture_pkg::reg_req_t reg_req,
   output logic [capture_pkg::DATA_W-1:0] reg_rdata,
   input wire logic capture_channel_pin,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   input wire capture_pkg::timer_values_t timer_values,
   output logic irq
);

   typedef struct packed {
      logic stop_in_idle;
      logic [2:0] time_base_select;
      logic [1:0] captures_per_interrupt;
      capture_pkg::mode_t capture_mode;
      logic overflow_flag;
      logic [3:0] channel_disable;
      logic [capture_pkg::DATA_W-1:0] periph_count;
      logic sync1;
      logic sync2;
      logic pin_prev;
      logic [3:0] presc_count;
      logic [1:0] cpi_count;
      logic [capture_pkg::PTR_W-1:0] head;
      logic [capture_pkg::PTR_W-1:0] tail;
      logic [2:0] fill;
      capture_pkg::irq_bits_t status;
      capture_pkg::irq_bits_t enable;
      logic irq;
      logic [capture_pkg::DATA_W-1:0] rdata;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic rise;
   logic fall;
   logic ch_off;
   logic running;
   logic presc_hit;
   logic edge_hit;
   logic capture;
   logic push;
   logic pop;
   logic ovf_evt;
   logic cpi_fire;
   logic wake;
   logic [capture_pkg::DATA_W-1:0] stamp;
   logic [capture_pkg::DATA_W-1:0] mem_rd_data;
   logic ctrl_wr;
   logic [2:0] wr_mode;

   // modes that store time stamps
   function automatic logic mode_captures(input capture_pkg::mode_t m);
      mode_captures = (m == capture_pkg::MODE_BOTH_EDGES) || (m == capture_pkg::MODE_FALLING) ||
         (m == capture_pkg::MODE_RISE_FOUR) || (m == capture_pkg::MODE_RISE_SIXTEEN);
   endfunction : mode_captures

   // time base mux, reserved codes stamp zero
   function automatic logic [capture_pkg::DATA_W-1:0] time_base(
      input logic [2:0] sel,
      input capture_pkg::timer_values_t tv,
      input logic [capture_pkg::DATA_W-1:0] periph
   );
      if (sel == capture_pkg::TB_PERIPH)
         time_base = periph;
      else if (sel == capture_pkg::TB_TIMER_FIVE)
         time_base = tv.five;
      else if (sel == capture_pkg::TB_TIMER_FOUR)
         time_base = tv.four;
      else if (sel == capture_pkg::TB_TIMER_TWO)
         time_base = tv.two;
      else if (sel == capture_pkg::TB_TIMER_THREE)
         time_base = tv.three;
      else
         time_base = capture_pkg::READ_IDLE;
   endfunction : time_base

   assign rise = s_q.sync2 & ~s_q.pin_prev;
   assign fall = ~s_q.sync2 & s_q.pin_prev;
   assign ch_off = s_q.channel_disable[0];
   // off, unused and spare modes never capture
   assign running = mode_captures(s_q.capture_mode) && !ch_off &&
      !(s_q.stop_in_idle && cpu_idle);
   assign presc_hit = (s_q.capture_mode == capture_pkg::MODE_RISE_SIXTEEN) ?
      (s_q.presc_count == capture_pkg::PRESC_LIMIT_SIXTEEN) :
      (s_q.presc_count == capture_pkg::PRESC_LIMIT_FOUR);

   always_comb
   begin
      case (s_q.capture_mode)
         capture_pkg::MODE_BOTH_EDGES: edge_hit = rise | fall;
         capture_pkg::MODE_FALLING: edge_hit = fall;
         capture_pkg::MODE_RISE_FOUR: edge_hit = rise & presc_hit;
         capture_pkg::MODE_RISE_SIXTEEN: edge_hit = rise & presc_hit;
         default: edge_hit = 1'h0;
      endcase
   end

   assign capture = running & edge_hit;
   assign push = capture && (s_q.fill != capture_pkg::FILL_FULL);
   assign ovf_evt = capture && (s_q.fill == capture_pkg::FILL_FULL);
   assign pop = reg_req.rd && (reg_req.addr == capture_pkg::OFS_BUFFER) && (s_q.fill != 3'h0);
   // every capture fires in both-edge mode
   assign cpi_fire = (s_q.capture_mode == capture_pkg::MODE_BOTH_EDGES) ||
      (s_q.cpi_count == s_q.captures_per_interrupt);
   assign wake = (s_q.capture_mode == capture_pkg::MODE_WAKE) && !ch_off && rise &&
      (cpu_sleep || cpu_idle);
   assign stamp = time_base(s_q.time_base_select, timer_values, s_q.periph_count);
   assign ctrl_wr = reg_req.wr && (reg_req.addr == capture_pkg::OFS_CONTROL_ONE);
   assign wr_mode = reg_req.wdata[capture_pkg::MODE_POS +: 3];

   always_comb
   begin
      capture_pkg::irq_bits_t ev;
      capture_pkg::irq_bits_t clr;
      ev = capture_pkg::IRQ_RESET;
      clr = capture_pkg::IRQ_RESET;
      s_d = s_q;
      s_d.sync1 = capture_channel_pin;
      s_d.sync2 = s_q.sync1;
      s_d.pin_prev = s_q.sync2;
      s_d.periph_count = s_q.periph_count + 16'h0001;
      s_d.rdata = capture_pkg::READ_IDLE;
      // prescaler counts rising edges in the prescaled modes
      if (running && rise &&
          ((s_q.capture_mode == capture_pkg::MODE_RISE_FOUR) ||
           (s_q.capture_mode == capture_pkg::MODE_RISE_SIXTEEN)))
      begin
         s_d.presc_count = presc_hit ? 4'h0 : s_q.presc_count + 4'h1;
      end
      if (capture)
      begin
         s_d.cpi_count = cpi_fire ? 2'h0 : s_q.cpi_count + 2'h1;
         ev.capture = cpi_fire;
      end
      ev.overflow = ovf_evt;
      ev.wake = wake;
      if (push)
      begin
         s_d.tail = s_q.tail + 2'h1;
      end
      if (pop)
      begin
         s_d.head = s_q.head + 2'h1;
      end
      s_d.fill = 3'(s_q.fill + {2'h0, push} - {2'h0, pop});
      if (reg_req.wr)
      begin
         if (reg_req.addr == capture_pkg::OFS_CONTROL_ONE)
         begin
            // status flag positions are not written
            s_d.stop_in_idle = reg_req.wdata[capture_pkg::STOP_IDLE_POS];
            s_d.time_base_select = reg_req.wdata[capture_pkg::TSEL_POS +: 3];
            s_d.captures_per_interrupt = reg_req.wdata[capture_pkg::CPI_POS +: 2];
            s_d.capture_mode = capture_pkg::mode_t'(wr_mode);
            if (wr_mode != s_q.capture_mode)
            begin
               s_d.cpi_count = 2'h0;
               s_d.presc_count = 4'h0;
            end
         end
         else if (reg_req.addr == capture_pkg::OFS_DISABLE_TWO)
         begin
            s_d.channel_disable = reg_req.wdata[capture_pkg::CH_DISABLE_POS +: 4];
         end
         else if (reg_req.addr == capture_pkg::OFS_IRQ_ENABLE)
         begin
            s_d.enable = reg_req.wdata[2:0];
         end
         else if (reg_req.addr == capture_pkg::OFS_IRQ_CLEAR)
         begin
            clr = reg_req.wdata[2:0];
         end
      end
      // switching off empties the buffer and restarts the counts
      if (s_d.capture_mode == capture_pkg::MODE_OFF)
      begin
         s_d.head = '0;
         s_d.tail = '0;
         s_d.fill = 3'h0;
         s_d.overflow_flag = 1'h0;
         s_d.cpi_count = 2'h0;
         s_d.presc_count = 4'h0;
      end
      if (ovf_evt)
      begin
         s_d.overflow_flag = 1'h1;
      end
      // a new event beats a clear in the same cycle
      s_d.status = (s_q.status & ~clr) | ev;
      s_d.irq = |(s_d.status & s_d.enable);
      if (reg_req.rd)
      begin
         if (reg_req.addr == capture_pkg::OFS_CONTROL_ONE)
         begin
            s_d.rdata[capture_pkg::STOP_IDLE_POS] = s_q.stop_in_idle;
            s_d.rdata[capture_pkg::TSEL_POS +: 3] = s_q.time_base_select;
            s_d.rdata[capture_pkg::CPI_POS +: 2] = s_q.captures_per_interrupt;
            s_d.rdata[capture_pkg::OVF_POS] = s_q.overflow_flag;
            s_d.rdata[capture_pkg::BNE_POS] = (s_q.fill != 3'h0);
            s_d.rdata[capture_pkg::MODE_POS +: 3] = s_q.capture_mode;
         end
         else if (reg_req.addr == capture_pkg::OFS_DISABLE_TWO)
         begin
            s_d.rdata[capture_pkg::CH_DISABLE_POS +: 4] = s_q.channel_disable;
         end
         else if (reg_req.addr == capture_pkg::OFS_BUFFER)
         begin
            s_d.rdata = mem_rd_data;
         end
         else if (reg_req.addr == capture_pkg::OFS_IRQ_STATUS)
         begin
            s_d.rdata[2:0] = s_q.status;
         end
         else if (reg_req.addr == capture_pkg::OFS_IRQ_ENABLE)
         begin
            s_d.rdata[2:0] = s_q.enable;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.channel_disable <= capture_pkg::DISABLE_RESET;
         s_q.status <= capture_pkg::IRQ_RESET;
         s_q.enable <= capture_pkg::IRQ_RESET;
         s_q.rdata <= capture_pkg::READ_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   capture_buffer_mem u_buffer (
      .core_clk(core_clk),
      .rst(rst),
      .wr_en(push),
      .wr_addr(s_q.tail),
      .wr_data(stamp),
      .rd_addr(s_d.head),
      .rd_data(mem_rd_data)
   );

   assign reg_rdata = s_q.rdata;
   assign irq = s_q.irq;

   chk_idle_halt: assert property (
      @(posedge core_clk) disable iff (rst)
      (s_q.stop_in_idle && cpu_idle) |-> !push)
      else $error("capture stored while halted in idle");
   chk_tsel_stamp: assert property (
      @(posedge core_clk) disable iff (rst)
      (push && s_q.time_base_select == capture_pkg::TB_TIMER_FIVE) |-> stamp == timer_values.five)
      else $error("time stamp not from selected time base");
   chk_cpi_fourth: assert property (
      @(posedge core_clk) disable iff (rst)
      (capture && s_q.captures_per_interrupt == 2'h3 &&
       s_q.capture_mode != capture_pkg::MODE_BOTH_EDGES)
      |=> s_q.status.capture == ($past(s_q.cpi_count) == 2'h3 || $past(s_q.status.capture)))
      else $error("capture interrupt count wrong");
   chk_cpi_ignored: assert property (
      @(posedge core_clk) disable iff (rst)
      (capture && s_q.capture_mode == capture_pkg::MODE_BOTH_EDGES) |=> s_q.status.capture)
      else $error("both-edge capture did not raise interrupt");
   chk_ovf_set: assert property (
      @(posedge core_clk) disable iff (rst)
      ovf_evt |=> s_q.overflow_flag && s_q.fill == capture_pkg::FILL_FULL || !running)
      else $error("overflow flag not set on full buffer");
   chk_bne_read: assert property (
      @(posedge core_clk) disable iff (rst)
      (reg_req.rd && reg_req.addr == capture_pkg::OFS_CONTROL_ONE)
      |=> reg_rdata[capture_pkg::BNE_POS] == ($past(s_q.fill) != 3'h0))
      else $error("not-empty flag disagrees with buffer");
   chk_flags_ro: assert property (
      @(posedge core_clk) disable iff (rst)
      (ctrl_wr && wr_mode == s_q.capture_mode && wr_mode != capture_pkg::MODE_OFF && !ovf_evt)
      |=> s_q.overflow_flag == $past(s_q.overflow_flag))
      else $error("software write changed overflow flag");
   chk_wake_only: assert property (
      @(posedge core_clk) disable iff (rst)
      (s_q.capture_mode == capture_pkg::MODE_WAKE) |-> !push ##1 (s_q.status.wake || !$past(wake)))
      else $error("wake mode misbehaved");
   chk_unused_off: assert property (
      @(posedge core_clk) disable iff (rst)
      (s_q.capture_mode == capture_pkg::MODE_UNUSED) |-> !capture)
      else $error("unused mode captured");
   chk_presc_sixteen: assert property (
      @(posedge core_clk) disable iff (rst)
      (push && s_q.capture_mode == capture_pkg::MODE_RISE_SIXTEEN)
      |-> rise && s_q.presc_count == 4'hF)
      else $error("sixteen-edge prescale wrong");
   chk_falling_only: assert property (
      @(posedge core_clk) disable iff (rst)
      (capture && s_q.capture_mode == capture_pkg::MODE_FALLING) |-> fall && !rise)
      else $error("falling mode captured without falling edge");
   chk_both_edges: assert property (
      @(posedge core_clk) disable iff (rst)
      (running && s_q.capture_mode == capture_pkg::MODE_BOTH_EDGES && (rise || fall)) |-> capture)
      else $error("edge missed in both-edge mode");
   chk_off_empty: assert property (
      @(posedge core_clk) disable iff (rst)
      (s_q.capture_mode == capture_pkg::MODE_OFF) |-> s_q.fill == 3'h0 && !capture)
      else $error("channel active while off");
   chk_disable_bit: assert property (
      @(posedge core_clk) disable iff (rst)
      s_q.channel_disable[0] |-> !capture && !wake)
      else $error("disabled channel active");
   chk_reserved_zero: assert property (
      @(posedge core_clk) disable iff (rst)
      (reg_req.rd && reg_req.addr == capture_pkg::OFS_DISABLE_TWO)
      |=> reg_rdata[15:12] == 4'h0 && reg_rdata[7:0] == 8'h00)
      else $error("reserved bits read nonzero");
   chk_push_fill: assert property (
      @(posedge core_clk) disable iff (rst)
      (push && !pop && !ctrl_wr) |=> s_q.fill == $past(s_q.fill) + 3'h1)
      else $error("capture not stored");
   chk_mode_restart: assert property (
      @(posedge core_clk) disable iff (rst)
      (ctrl_wr && wr_mode != s_q.capture_mode) |=> s_q.cpi_count == 2'h0)
      else $error("capture count not restarted");

endmodule : input_capture_control
`default_nettype wire

// [capture_source.sv]
// far side model: drives the capture pin and the four timer counts
`timescale 1ns/1ps
`default_nettype none
module capture_source #(
   parameter logic [15:0] TWO_VAL = 16'h0000,
   parameter logic [15:0] THREE_VAL = 16'h0000,
   parameter logic [15:0] FOUR_VAL = 16'h0000,
   parameter logic [15:0] FIVE_VAL = 16'h0000
) (
   input wire logic core_clk,
   input wire logic drive_level,
   output logic capture_channel_pin,
   output var capture_pkg::timer_values_t timer_values
);
   // timers held still so a stamp is known before the edge
   assign timer_values = '{two: TWO_VAL, three: THREE_VAL, four: FOUR_VAL, five: FIVE_VAL};
   always_ff @(posedge core_clk)
   begin
      capture_channel_pin <= drive_level;
   end
endmodule : capture_source
`default_nettype wire

// [input_capture_control_test.sv]
// bench for the input capture channel: registers, edge modes, flags and interrupt
`timescale 1ns/1ps
`default_nettype none
module input_capture_control_test;
   localparam logic [15:0] T2 = 16'h2a2a;
   localparam logic [15:0] T3 = 16'h3b3b;
   localparam logic [15:0] T4 = 16'h4c4c;
   localparam logic [15:0] T5 = 16'h5d5d;
   typedef struct {
      logic [15:0] ctrl;
      int pulses;
      logic bne;
      logic [15:0] stamp;
   } row_t;
   logic core_clk;
   logic rst;
   capture_pkg::reg_req_t reg_req;
   logic [15:0] reg_rdata;
   logic drive_level;
   logic capture_channel_pin;
   logic cpu_idle;
   logic cpu_sleep;
   logic irq;
   capture_pkg::timer_values_t timer_values;
   logic [15:0] v;
   int n_fail;
   int tests_run;
   logic [15:0] cyc;
   logic [15:0] stamp_exp;
   row_t rows [15];

   capture_source #(.TWO_VAL(T2), .THREE_VAL(T3), .FOUR_VAL(T4), .FIVE_VAL(T5)) far_side (
      .core_clk(core_clk),
      .drive_level(drive_level),
      .capture_channel_pin(capture_channel_pin),
      .timer_values(timer_values)
   );
   input_capture_control uut (
      .core_clk(core_clk),
      .rst(rst),
      .reg_req(reg_req),
      .reg_rdata(reg_rdata),
      .capture_channel_pin(capture_channel_pin),
      .cpu_idle(cpu_idle),
      .cpu_sleep(cpu_sleep),
      .timer_values(timer_values),
      .irq(irq)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // own copy of the free-running peripheral time base
   always_ff @(posedge core_clk)
   begin
      cyc <= rst ? 16'h0000 : cyc + 16'h0001;
   end

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      reg_req.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      reg_req.rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   // one full high then low pulse, each level held past the sync delay
   task automatic pulse;
      @(posedge core_clk);
      drive_level <= 1'b1;
      repeat (4) @(posedge core_clk);
      drive_level <= 1'b0;
      repeat (4) @(posedge core_clk);
      // step past the edge so outputs launched there have settled
      #1;
   endtask : pulse

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out

   initial
   begin
      #900_000;
      n_fail++;
      close_out();
   end

   initial
   begin
      reg_req = '0;
      drive_level = 1'b0;
      cpu_idle = 1'b0;
      cpu_sleep = 1'b0;
      n_fail = 0;
      tests_run = 0;
      rst = 1'b1;
      rows = '{'{16'h0003, 1, 1'b1, T3}, '{16'h0403, 1, 1'b1, T2}, '{16'h0803, 1, 1'b1, T4},
         '{16'h0c03, 1, 1'b1, T5}, '{16'h1403, 1, 1'b1, 16'h0000},
         '{16'h1803, 1, 1'b1, 16'h0000}, '{16'h0001, 1, 1'b1, T3}, '{16'h0004, 3, 1'b0, 16'h0000},
         '{16'h0004, 4, 1'b1, T3}, '{16'h0005, 15, 1'b0, 16'h0000}, '{16'h0005, 16, 1'b1, T3},
         '{16'h0006, 2, 1'b0, 16'h0000}, '{16'h0000, 2, 1'b0, 16'h0000},
         '{16'h0002, 2, 1'b0, 16'h0000}, '{16'h1003, 1, 1'b1, 16'h0000}};
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         wr(capture_pkg::OFS_CONTROL_ONE, 16'h0000);
         // reserved and read-only positions written high on purpose
         wr(capture_pkg::OFS_CONTROL_ONE, rows[i].ctrl | 16'hc398);
         repeat (rows[i].pulses) pulse();
         rd(capture_pkg::OFS_CONTROL_ONE, v);
         chk(v, rows[i].ctrl | {12'h000, rows[i].bne, 3'h0});
         if (rows[i].bne)
         begin
            rd(capture_pkg::OFS_BUFFER, v);
            chk(v, rows[i].stamp);
         end
      end
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0000);
      // overflow, flags and interrupt
      wr(capture_pkg::OFS_IRQ_ENABLE, 16'h0002);
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0003);
      repeat (5) pulse();
      rd(capture_pkg::OFS_CONTROL_ONE, v);
      chk(v, 16'h001b);
      chk({15'h0000, irq}, 16'h0001);
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0003);
      repeat (4)
      begin
         rd(capture_pkg::OFS_BUFFER, v);
         chk(v, T3);
      end
      rd(capture_pkg::OFS_CONTROL_ONE, v);
      chk(v, 16'h0013);
      wr(capture_pkg::OFS_IRQ_CLEAR, 16'h0002);
      rd(capture_pkg::OFS_IRQ_CLEAR, v);
      chk({v[15:1], irq}, 16'h0000);
      wr(4'hc, 16'hffff);
      rd(4'hc, v);
      chk(v, 16'h0000);
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0000);
      rd(capture_pkg::OFS_CONTROL_ONE, v);
      chk(v, 16'h0000);
      // captures per interrupt
      wr(capture_pkg::OFS_IRQ_ENABLE, 16'h0001);
      for (int n = 1; n < 4; n++)
      begin
         wr(capture_pkg::OFS_CONTROL_ONE, 16'h0000);
         wr(capture_pkg::OFS_CONTROL_ONE, 16'h0003 | 16'(n << 5));
         wr(capture_pkg::OFS_IRQ_CLEAR, 16'h0007);
         repeat (n) pulse();
         chk({15'h0000, irq}, 16'h0000);
         pulse();
         chk({15'h0000, irq}, 16'h0001);
      end
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0000);
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0061);
      wr(capture_pkg::OFS_IRQ_CLEAR, 16'h0007);
      pulse();
      chk({15'h0000, irq}, 16'h0001);
      // stop in idle
      wr(capture_pkg::OFS_IRQ_ENABLE, 16'h0000);
      cpu_idle <= 1'b1;
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0000);
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h2003);
      pulse();
      rd(capture_pkg::OFS_CONTROL_ONE, v);
      chk(v, 16'h2003);
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0003);
      pulse();
      rd(capture_pkg::OFS_CONTROL_ONE, v);
      chk(v, 16'h000b);
      @(posedge core_clk);
      cpu_idle <= 1'b0;
      // channel disable bit
      wr(capture_pkg::OFS_DISABLE_TWO, 16'hffff);
      rd(capture_pkg::OFS_DISABLE_TWO, v);
      chk(v, 16'h0f00);
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0000);
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0003);
      pulse();
      rd(capture_pkg::OFS_CONTROL_ONE, v);
      chk(v, 16'h0003);
      wr(capture_pkg::OFS_DISABLE_TWO, 16'h0000);
      pulse();
      rd(capture_pkg::OFS_CONTROL_ONE, v);
      chk(v, 16'h000b);
      // peripheral clock time base stamps the free-running count
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0000);
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h1c03);
      pulse();
      stamp_exp = cyc - 16'h0001;
      rd(capture_pkg::OFS_BUFFER, v);
      chk(v, stamp_exp);
      // wake input only while sleeping or idle, checked awake then asleep
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h0000);
      wr(capture_pkg::OFS_IRQ_ENABLE, 16'h0004);
      wr(capture_pkg::OFS_IRQ_CLEAR, 16'h0007);
      wr(capture_pkg::OFS_CONTROL_ONE, 16'h2067);
      pulse();
      rd(capture_pkg::OFS_IRQ_STATUS, v);
      chk(v, 16'h0000);
      @(posedge core_clk);
      cpu_sleep <= 1'b1;
      pulse();
      rd(capture_pkg::OFS_IRQ_STATUS, v);
      chk(v, 16'h0004);
      chk({15'h0000, irq}, 16'h0001);
      close_out();
   end
endmodule : input_capture_control_test
`default_nettype wire
